/* gamma_dac_consts.vh */
// constants for the gamma reference two-wire slave
`ifndef GAMMA_DAC_CONSTS_VH
`define GAMMA_DAC_CONSTS_VH
`define CH_COUNT 20
`define CODE_W 10
`define HALF_SPAN 10'h200
`define SLAVE_ADDR_HI 6'h3a
`define GCALL_ADDR 8'h00
`define GCALL_RESET 8'h06
`define HS_CODE_HI 5'h01
`define CMD_RESET_ALL 3'h4
`define CMD_RESET_ONE 3'h2
`define CMD_NORMAL 3'h0
`define LATCH_ALL_BIT 15
`define FILTER_LEN 3
`endif

/* line_filter.v */
// two-flop synchroniser followed by an all-samples-agree stability filter
module line_filter #(
  parameter LEN = 3,
  parameter INIT = 1'b1
) (
  input wire clk,
  input wire sys_rst,
  input wire raw,
  output reg clean
);
  reg s1_q;
  reg s2_q;
  reg [LEN-1:0] hist_q;
  always @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      hist_q <= {LEN{INIT}};
      clean <= INIT;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      hist_q <= {hist_q[LEN-2:0], s2_q};
      // a level must stand LEN+1 samples before it is accepted; this rejects spikes
      if (&{hist_q, s2_q})
        clean <= 1'b1;
      else if (~|{hist_q, s2_q})
        clean <= 1'b0;
    end
  end
endmodule // line_filter

/* gamma_dac_twowire_slave.v */
// two-wire slave with double-buffered 20-channel 10-bit code registers
`include "gamma_dac_consts.vh"
module gamma_dac_twowire_slave #(
  parameter CH = `CH_COUNT,
  parameter W = `CODE_W
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe,
  input wire addr_select_pin,
  input wire output_load_pin,
  output reg [CH*W-1:0] latch_codes,
  output reg hs_mode
);
  localparam S_IDLE = 7'h01;
  localparam S_ADDR = 7'h02;
  localparam S_CHAN = 7'h04;
  localparam S_WDATA = 7'h08;
  localparam S_RDATA = 7'h10;
  localparam S_GCALL = 7'h20;
  localparam S_IGNORE = 7'h40;

  wire scl_f;
  wire sda_f;
  wire ld_f;
  line_filter #(.LEN(`FILTER_LEN), .INIT(1'b1)) u_scl (
    .clk(clk), .sys_rst(sys_rst), .raw(scl_in), .clean(scl_f));
  line_filter #(.LEN(`FILTER_LEN), .INIT(1'b1)) u_sda (
    .clk(clk), .sys_rst(sys_rst), .raw(sda_in), .clean(sda_f));
  line_filter #(.LEN(`FILTER_LEN), .INIT(1'b0)) u_ld (
    .clk(clk), .sys_rst(sys_rst), .raw(output_load_pin), .clean(ld_f));
  // the strap is a pin as well, so it is synchronised like the bus lines
  wire asel_f;
  line_filter #(.LEN(`FILTER_LEN), .INIT(1'b0)) u_asel (
    .clk(clk), .sys_rst(sys_rst), .raw(addr_select_pin), .clean(asel_f));

  // latch_codes feed the converters: output = low ref + code * span / 1024
  reg scl_q;
  reg sda_q;
  reg ld_q;
  reg [W-1:0] store_q [0:CH-1];
  reg [6:0] state_q;
  reg [3:0] bit_q;
  reg [7:0] shift_q;
  reg [4:0] chan_q;
  reg first_q;
  reg [7:0] hi_q;
  // read byte being shifted out, msb first
  reg [7:0] tx_q;
  reg ack_q;
  reg rd_stop_q;
  reg gc_arm_q;
  reg gc_reset_q;
  // decoded response to the byte now completing
  reg dec_ack;
  reg dec_hs;
  reg dec_gc;
  reg [6:0] dec_state;
  integer i;

  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire start_c = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_c = scl_f & scl_q & ~sda_q & sda_f;
  wire ld_fall = ld_q & ~ld_f;
  wire [7:0] byte_in = {shift_q[6:0], sda_f};

  function [4:0] next_chan;
    input [4:0] c;
    begin
      next_chan = (c == CH - 1) ? 5'h00 : c + 5'h01;
    end
  endfunction

  function [W-1:0] latch_of;
    input [CH*W-1:0] v;
    input [4:0] c;
    begin
      latch_of = v[c*W +: W];
    end
  endfunction

  function chan_ok;
    input [4:0] c;
    begin
      chan_ok = (c < CH);
    end
  endfunction

  // only plain, reset-all and reset-one commands are accepted in the top bits
  function cmd_ok;
    input [2:0] cmd;
    begin
      cmd_ok = (cmd == `CMD_NORMAL) || (cmd == `CMD_RESET_ALL) || (cmd == `CMD_RESET_ONE);
    end
  endfunction

  function is_hs_code;
    input [7:0] b;
    begin
      is_hs_code = (b[7:3] == `HS_CODE_HI);
    end
  endfunction

  // reads send the converter latch, not the storage register, as msb then lsb
  function [7:0] read_byte;
    input [W-1:0] code;
    input hi;
    reg [15:0] word;
    begin
      word = {{(16-W){1'b0}}, code};
      read_byte = hi ? word[15:8] : word[7:0];
    end
  endfunction

  wire [W-1:0] wr_code = {hi_q[W-9:0], byte_in};
  wire [7:0] rd_byte = read_byte(latch_of(latch_codes, chan_q), first_q);

  // edge history; a general-call reset leaves it alone so no false edge follows
  always @(posedge clk) begin
    if (sys_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ld_q <= 1'b0;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
      ld_q <= ld_f;
    end
  end

  // decode of a completed byte by the phase it arrived in
  always @* begin
    dec_ack = 1'b0;
    dec_hs = 1'b0;
    dec_gc = 1'b0;
    dec_state = S_IGNORE;
    case (state_q)
      S_ADDR: begin
        if (is_hs_code(byte_in)) begin
          // low three bits belong to the master; no read/write meaning
          dec_hs = 1'b1;
        end else if (byte_in == `GCALL_ADDR) begin
          dec_ack = 1'b1;
          dec_state = S_GCALL;
        end else if (byte_in[7:1] == {`SLAVE_ADDR_HI, asel_f}) begin
          dec_ack = 1'b1;
          dec_state = byte_in[0] ? S_RDATA : S_CHAN;
        end
      end
      S_GCALL: begin
        dec_ack = (byte_in == `GCALL_RESET);
        dec_gc = (byte_in == `GCALL_RESET);
      end
      S_CHAN: begin
        if (chan_ok(byte_in[4:0]) && cmd_ok(byte_in[7:5])) begin
          dec_ack = 1'b1;
          dec_state = S_WDATA;
        end
      end
      S_WDATA: begin
        dec_ack = 1'b1;
        dec_state = S_WDATA;
      end
      S_RDATA: begin
        // the master acknowledges read bytes, never the slave
        dec_state = S_RDATA;
      end
      default: begin
        // an ignored transfer still counts bits so the ninth pulse stays aligned
        dec_state = S_IGNORE;
      end
    endcase
  end

  // byte engine: bit_q counts rising edges 1..8, 9 marks the acknowledge pulse
  always @(posedge clk) begin
    if (sys_rst || gc_reset_q) begin
      // power-up and general-call reset load both register stages at once
      for (i = 0; i < CH; i = i + 1) begin
        store_q[i] <= `HALF_SPAN;
        latch_codes[i*W +: W] <= `HALF_SPAN;
      end
      state_q <= S_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      chan_q <= 5'h00;
      first_q <= 1'b1;
      hi_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      rd_stop_q <= 1'b0;
      gc_arm_q <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      hs_mode <= 1'b0;
      gc_reset_q <= 1'b0;
    end else begin
      sda_out <= 1'b0; // open drain: only ever pulls low
      if (ld_fall) begin
        for (i = 0; i < CH; i = i + 1) begin
          latch_codes[i*W +: W] <= store_q[i];
        end
      end
      if (stop_c) begin
        // a stop drops any half-received word and ends high-speed
        state_q <= S_IDLE;
        bit_q <= 4'h0;
        hs_mode <= 1'b0;
        sda_oe <= 1'b0;
        gc_arm_q <= 1'b0;
      end else if (start_c) begin
        // a repeated start keeps high-speed and drops any partial word
        state_q <= S_ADDR;
        bit_q <= 4'h0;
        sda_oe <= 1'b0;
        gc_arm_q <= 1'b0;
      end else if (scl_rise) begin
        // bits are taken on the rising clock, msb first
        bit_q <= bit_q + 4'h1;
        if (bit_q < 4'h8) begin
          shift_q <= byte_in;
        end
        if (bit_q == 4'h8 && state_q == S_RDATA) begin
          rd_stop_q <= sda_f; // master nack ends the read
        end
        if (bit_q == 4'h7) begin
          ack_q <= dec_ack;
          state_q <= dec_state;
          if (dec_hs) begin
            hs_mode <= 1'b1;
          end
          if (dec_gc) begin
            // the reset waits until the acknowledge pulse is over
            gc_arm_q <= 1'b1;
          end
          if (state_q == S_ADDR && dec_state == S_RDATA) begin
            first_q <= 1'b1;
            rd_stop_q <= 1'b0;
          end
          if (state_q == S_CHAN && dec_ack) begin
            chan_q <= byte_in[4:0];
            first_q <= 1'b1;
            if (byte_in[7:5] == `CMD_RESET_ALL) begin
              for (i = 0; i < CH; i = i + 1) begin
                store_q[i] <= `HALF_SPAN;
                latch_codes[i*W +: W] <= `HALF_SPAN;
              end
            end else if (byte_in[7:5] == `CMD_RESET_ONE) begin
              store_q[byte_in[4:0]] <= `HALF_SPAN;
              latch_codes[byte_in[4:0]*W +: W] <= `HALF_SPAN;
            end
          end
          if (state_q == S_WDATA) begin
            first_q <= ~first_q;
            if (first_q) begin
              hi_q <= byte_in;
            end else begin
              store_q[chan_q] <= wr_code;
              if (!ld_f) begin
                latch_codes[chan_q*W +: W] <= wr_code;
              end else if (hi_q[`LATCH_ALL_BIT-8]) begin
                // the word being written goes straight in; the rest come from storage
                for (i = 0; i < CH; i = i + 1) begin
                  latch_codes[i*W +: W] <= (i == chan_q) ? wr_code : store_q[i];
                end
              end
              chan_q <= next_chan(chan_q);
            end
          end
        end
      end else if (scl_fall) begin
        if (bit_q == 4'h8) begin
          // drive acknowledge for the ninth pulse, or release for the master's
          sda_oe <= ack_q;
        end else if (bit_q == 4'h9) begin
          // end of the acknowledge pulse: release, then prepare the next read byte
          bit_q <= 4'h0;
          sda_oe <= 1'b0;
          if (gc_arm_q) begin
            gc_reset_q <= 1'b1;
          end
          if (state_q == S_RDATA) begin
            if (rd_stop_q) begin
              // a master nack releases the line until the next start
              state_q <= S_IGNORE;
            end else begin
              tx_q <= {rd_byte[6:0], 1'b0};
              sda_oe <= ~rd_byte[7];
              first_q <= ~first_q;
              if (!first_q) begin
                chan_q <= next_chan(chan_q);
              end
            end
          end
        end else if (state_q == S_RDATA && bit_q != 4'h0) begin
          // read bits move only after the clock falls
          tx_q <= {tx_q[6:0], 1'b0};
          sda_oe <= ~tx_q[7];
        end
      end
    end
  end
endmodule // gamma_dac_twowire_slave

/* gamma_dac_asserts.sv */
// concurrent checks on the ports of the gamma reference two-wire slave
`include "gamma_dac_consts.vh"
module gamma_dac_asserts #(
  parameter CH = 20,
  parameter W = 10
) (
  input wire clk,
  input wire sys_rst,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire addr_select_pin,
  input wire output_load_pin,
  input wire [CH*W-1:0] latch_codes,
  input wire hs_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_RST_HALF: assert property (disable iff (1'b0) sys_rst |=> latch_codes == {CH{`HALF_SPAN}})
    else $error("latches not half-span after reset");
  AST_RST_IDLE: assert property (disable iff (1'b0) sys_rst |=> !sda_oe && !hs_mode)
    else $error("slave active after reset");
  AST_LOW_ONLY: assert property (sda_oe |-> !sda_out)
    else $error("data line driven high");
  AST_OE_HOLD: assert property ($rose(sda_oe) |=> sda_oe [*8])
    else $error("data drive too short");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed with clock high");
  AST_HS_EXIT: assert property ($rose(sda_in) && scl_in && hs_mode |-> ##[1:20] !hs_mode)
    else $error("high-speed kept after stop");
  AST_HS_FELL_SCL: assert property ($fell(hs_mode) |-> scl_in)
    else $error("high-speed left outside stop");
  AST_HS_NO_ACK: assert property ($rose(hs_mode) |-> !sda_oe)
    else $error("high-speed code acknowledged");
endmodule // gamma_dac_asserts

/* twowire_master_model.sv */
// behavioural two-wire bus master; clock stands high outside frames
module twowire_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // data moves only while clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #40 scl = 1'b1;
    #40 r = sda_line;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic start();
    sda_low = 1'b0;
    #40 scl = 1'b1;
    #40 sda_low = 1'b1;
    #40 scl = 1'b0;
    #40;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    #40 scl = 1'b1;
    #40 sda_low = 1'b0;
    #80;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule // twowire_master_model

/* tb.sv */
// self-checking bench for the gamma reference two-wire slave
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic addr_select_pin = 1'b0;
  logic output_load_pin = 1'b0;
  logic scl;
  logic sda_low;
  logic a;
  logic [7:0] d0;
  logic [7:0] d1;
  wire sda_out;
  wire sda_oe;
  wire hs_mode;
  wire [199:0] latch_codes;
  int miscompares = 0;
  int checks = 0;
  // open-drain line with pull-up
  wire sda_line = !(sda_low || (sda_oe && !sda_out));
  initial forever #2.5 clk = ~clk;
  twowire_master_model u_twowire_master_model (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
  gamma_dac_twowire_slave u_gamma_dac_twowire_slave (.clk(clk), .sys_rst(sys_rst),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_pin(addr_select_pin), .output_load_pin(output_load_pin),
    .latch_codes(latch_codes), .hs_mode(hs_mode));
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [9:0] ch(int i);
    return latch_codes[i*10 +: 10];
  endfunction
  task automatic go();
    @(negedge clk);
    u_twowire_master_model.start();
  endtask
  // stop, then let the synchronisers settle
  task automatic fin();
    u_twowire_master_model.stop();
    repeat (20) @(negedge clk);
  endtask
  task automatic x(logic [7:0] b, logic e);
    u_twowire_master_model.wbyte(b, a);
    chk("ack", e, a);
  endtask
  task automatic t_addr();
    for (int s = 0; s < 2; s++) begin
      addr_select_pin = s[0];
      go(); x({6'h3a, !s[0], 1'b0}, 0); fin();
      go(); x({6'h3a, s[0], 1'b0}, 1); x(8'h14, 0); fin();
    end
  endtask
  task automatic t_write();
    go(); x(8'hea, 1); x(8'h12, 1); x(8'h03, 1); x(8'hff, 1); x(8'h01, 1); x(8'h55, 1); fin();
    chk("ch18", 10'h3ff, ch(18));
    chk("ch19", 10'h155, ch(19));
    output_load_pin = 1'b1;
    go(); x(8'hea, 1); x(8'h00, 1); x(8'h01, 1); x(8'h55, 1); fin();
    chk("ch0 held", 10'h200, ch(0));
    go(); x(8'hea, 1); x(8'h01, 1); x(8'h02, 1); fin();
    output_load_pin = 1'b0;
    repeat (20) @(negedge clk);
    chk("ch0 load", 10'h155, ch(0));
    chk("ch1 partial", 10'h200, ch(1));
    output_load_pin = 1'b1;
    go(); x(8'hea, 1); x(8'h02, 1); x(8'h80, 1); x(8'h01, 1); fin();
    chk("ch2 sw", 10'h001, ch(2));
  endtask
  task automatic t_read();
    go(); x(8'hea, 1); x(8'h02, 1); x(8'h02, 1); x(8'haa, 1); fin();
    go(); x(8'hea, 1); x(8'h02, 1); go(); x(8'heb, 1);
    u_twowire_master_model.rbyte(1'b1, d0);
    u_twowire_master_model.rbyte(1'b0, d1);
    fin();
    chk("read", 16'h0001, {d0, d1});
  endtask
  task automatic t_gc();
    go(); x(8'h00, 1); x(8'h05, 0); fin();
    go(); x(8'h00, 1); x(8'h06, 1); fin();
    chk("gc latch", 10'h200, ch(2));
    output_load_pin = 1'b0;
    repeat (20) @(negedge clk);
    chk("gc store", 10'h200, ch(2));
    go(); x(8'hea, 1); x(8'h00, 1); x(8'h00, 1); x(8'haa, 1); go(); x(8'hea, 1); x(8'h80, 1); fin();
    chk("reset all", 10'h200, ch(0));
    go(); x(8'hea, 1); x(8'h00, 1); x(8'h01, 1); x(8'h23, 1); x(8'h00, 1); x(8'haa, 1);
    go(); x(8'hea, 1); x(8'h41, 1); fin();
    chk("reset one", 10'h200, ch(1));
    chk("reset one other", 10'h123, ch(0));
  endtask
  task automatic t_hs();
    go(); x(8'h0d, 0);
    chk("hs on", 1, hs_mode);
    go(); x(8'hea, 1);
    chk("hs kept", 1, hs_mode);
    fin();
    chk("hs off", 0, hs_mode);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    for (int i = 0; i < 20; i++) chk("reset", 10'h200, ch(i));
    t_addr();
    t_write();
    t_read();
    t_gc();
    t_hs();
    finish_test();
  end
  initial begin
    #300000;
    miscompares++;
    finish_test();
  end
endmodule // tb
bind gamma_dac_twowire_slave gamma_dac_asserts #(.CH(CH), .W(W)) u_gamma_dac_asserts (
  .clk(clk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .addr_select_pin(addr_select_pin), .output_load_pin(output_load_pin),
  .latch_codes(latch_codes), .hs_mode(hs_mode));
